// ==== hw/i2r_rate_addr.sv ====
`default_nettype none
module i2r_rate_addr (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Serial clock pin
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   // Serial data pin
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Transfer control side
   output logic addr_match_o
);
   // *****************************************************
   // Pin synchronisers
   // *****************************************************
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_q_reg;
   logic sda_q_reg;
   logic scl_s;
   logic sda_s;
   assign scl_s = scl_sync_reg[1];
   assign sda_s = sda_sync_reg[1];

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end
      else
      begin
         scl_sync_reg <= {scl_sync_reg[0], scl_i};
         sda_sync_reg <= {sda_sync_reg[0], sda_i};
         scl_q_reg <= scl_s;
         sda_q_reg <= sda_s;
      end
   end

   // *****************************************************
   // APB register file
   // *****************************************************
   logic [6:0] own_addr_reg;
   logic [7:0] rate_reg;
   logic [1:0] ctrl_reg;
   logic [31:0] prdata_reg;
   logic [4:0] status_w;
   logic [31:0] rd_data;
   logic sel_id;
   logic sel_rate;
   logic sel_ctrl;
   logic sel_cmd;
   logic sel_stat;
   logic hit;
   logic wr_en;
   logic cmd_wr;
   logic busy;
   assign sel_id = paddr_i == i2r_pkg::OFS_TARGET_ID;
   assign sel_rate = paddr_i == i2r_pkg::OFS_RATE;
   assign sel_ctrl = paddr_i == i2r_pkg::OFS_CTRL;
   assign sel_cmd = paddr_i == i2r_pkg::OFS_CMD;
   assign sel_stat = paddr_i == i2r_pkg::OFS_STATUS;
   assign hit = sel_id | sel_rate | sel_ctrl | sel_cmd | sel_stat;
   assign wr_en = psel_i & penable_i & pwrite_i;
   assign cmd_wr = wr_en & sel_cmd & ~busy & ctrl_reg[i2r_pkg::CTRL_EN];
   assign rd_data = sel_id ? {24'h000000, own_addr_reg, 1'b0} :
                    sel_rate ? {24'h000000, rate_reg} :
                    sel_ctrl ? {30'h00000000, ctrl_reg} :
                    sel_stat ? {27'h0000000, status_w} : 32'h00000000;
   assign prdata_o = prdata_reg;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~hit;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         own_addr_reg <= i2r_pkg::TARGET_ID_RST;
         rate_reg <= i2r_pkg::RATE_RST;
         ctrl_reg <= i2r_pkg::CTRL_RST;
         prdata_reg <= 32'h00000000;
      end
      else
      begin
         if (wr_en & sel_id)
            own_addr_reg <= pwdata_i[i2r_pkg::ID_ADDR_LSB +: 7];
         if (wr_en & sel_rate)
            rate_reg <= pwdata_i[7:0];
         if (wr_en & sel_ctrl)
            ctrl_reg <= pwdata_i[1:0];
         if (psel_i & ~penable_i)
            prdata_reg <= rd_data;
      end
   end

   // *****************************************************
   // Divider and hold selection
   // *****************************************************
   logic [5:0] idx;
   logic [1:0] scale;
   logic [4:0] base_idx;
   logic [2:0] k_w;
   logic [1:0] ms_w;
   i2r_pkg::i2r_entry_t entry;
   logic [15:0] b_div;
   logic [15:0] b_sda;
   logic [15:0] b_start;
   logic [15:0] b_stop;
   logic [15:0] sc_div;
   logic [15:0] sc_sda;
   logic [15:0] sc_start;
   logic [15:0] sc_stop;
   logic [15:0] period;
   logic [15:0] sda_hold;
   logic [15:0] start_hold;
   logic [15:0] stop_hold;
   logic [15:0] half_low;
   logic [15:0] half_high;
   assign idx = rate_reg[i2r_pkg::RATE_IDX_LSB +: 6];
   assign scale = rate_reg[i2r_pkg::RATE_SCALE_LSB +: 2];
   // Indices 20..3F scale the 18..1F row by powers of two
   assign base_idx = idx[5] ? {2'h3, idx[2:0]} : idx[4:0];
   assign k_w = idx[5] ? {1'b0, idx[4:3]} + 3'h1 : 3'h0;
   assign entry = i2r_pkg::RATE_TABLE[base_idx];
   assign b_div = {8'h00, entry[31:24]};
   assign b_sda = {8'h00, entry[23:16]};
   assign b_start = {8'h00, entry[15:8]};
   assign b_stop = {8'h00, entry[7:0]};
   assign sc_div = b_div << k_w;
   assign sc_sda = ((b_sda - 16'h0001) << k_w) + 16'h0001;
   assign sc_start = ((b_start + 16'h0002) << k_w) - 16'h0002;
   assign sc_stop = idx[5] ? sc_start + 16'h0003 : b_stop;
   // Reserved scale code falls back to a factor of one
   assign ms_w = (scale == i2r_pkg::SCALE_X4) ? 2'h2 :
                 (scale == i2r_pkg::SCALE_X2) ? 2'h1 : 2'h0;
   assign period = sc_div << ms_w;
   assign sda_hold = sc_sda << ms_w;
   assign start_hold = sc_start << ms_w;
   assign stop_hold = sc_stop << ms_w;
   assign half_low = {1'b0, period[15:1]};
   assign half_high = period - half_low;

   // *****************************************************
   // Bus sequencer
   // *****************************************************
   i2r_pkg::i2r_state_t state_reg;
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [3:0] bit_cnt_reg;
   logic [7:0] tx_reg;
   logic pend_start_reg;
   logic pend_byte_reg;
   logic pend_stop_reg;
   logic nack_reg;
   logic scl_drv_reg;
   logic sda_drv_reg;
   assign cnt_next = cnt_reg + 16'h0001;
   assign busy = (state_reg != i2r_pkg::S_IDLE) | pend_start_reg |
                 pend_byte_reg | pend_stop_reg;
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = scl_drv_reg;
   assign sda_oe_o = sda_drv_reg;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_reg <= i2r_pkg::S_IDLE;
         cnt_reg <= 16'h0000;
         bit_cnt_reg <= 4'h0;
         tx_reg <= 8'h00;
         pend_start_reg <= 1'b0;
         pend_byte_reg <= 1'b0;
         pend_stop_reg <= 1'b0;
         nack_reg <= 1'b0;
         scl_drv_reg <= 1'b0;
         sda_drv_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         if (cmd_wr)
         begin
            pend_start_reg <= pwdata_i[i2r_pkg::CMD_START];
            pend_byte_reg <= pwdata_i[i2r_pkg::CMD_BYTE];
            pend_stop_reg <= pwdata_i[i2r_pkg::CMD_STOP];
            tx_reg <= pwdata_i[i2r_pkg::CMD_DATA_LSB +: 8];
         end
         unique case (state_reg)
            i2r_pkg::S_IDLE:
            begin
               cnt_reg <= 16'h0000;
               if (pend_start_reg & scl_s & sda_s)
               begin
                  sda_drv_reg <= 1'b1;
                  state_reg <= i2r_pkg::S_START;
               end
               // Clock line fell one cycle ago, count from one
               else if (pend_byte_reg & ~pend_start_reg)
               begin
                  bit_cnt_reg <= 4'h0;
                  cnt_reg <= 16'h0001;
                  state_reg <= i2r_pkg::S_LOW;
               end
               else if (pend_stop_reg & ~pend_start_reg & ~pend_byte_reg)
               begin
                  cnt_reg <= 16'h0001;
                  state_reg <= i2r_pkg::S_STOP_LOW;
               end
            end
            i2r_pkg::S_START:
               if (cnt_next >= start_hold)
               begin
                  scl_drv_reg <= 1'b1;
                  pend_start_reg <= 1'b0;
                  state_reg <= i2r_pkg::S_IDLE;
               end
            i2r_pkg::S_LOW:
            begin
               if (cnt_next == sda_hold)
                  sda_drv_reg <= (bit_cnt_reg == 4'h8) ? 1'b0 : ~tx_reg[7];
               if (cnt_next >= half_low)
               begin
                  scl_drv_reg <= 1'b0;
                  cnt_reg <= 16'h0000;
                  state_reg <= i2r_pkg::S_HIGH;
               end
            end
            i2r_pkg::S_HIGH:
               // Waits out clock stretching by other parties
               if (cnt_next >= half_high && scl_s)
               begin
                  scl_drv_reg <= 1'b1;
                  cnt_reg <= 16'h0000;
                  if (bit_cnt_reg == 4'h8)
                  begin
                     nack_reg <= sda_s;
                     pend_byte_reg <= 1'b0;
                     state_reg <= i2r_pkg::S_IDLE;
                  end
                  else
                  begin
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     tx_reg <= {tx_reg[6:0], 1'b0};
                     state_reg <= i2r_pkg::S_LOW;
                  end
               end
            i2r_pkg::S_STOP_LOW:
            begin
               if (cnt_next == sda_hold)
                  sda_drv_reg <= 1'b1;
               if (cnt_next >= half_low)
               begin
                  scl_drv_reg <= 1'b0;
                  cnt_reg <= 16'h0000;
                  state_reg <= i2r_pkg::S_STOP_HOLD;
               end
            end
            i2r_pkg::S_STOP_HOLD:
               if (cnt_next >= stop_hold && scl_s)
               begin
                  sda_drv_reg <= 1'b0;
                  pend_stop_reg <= 1'b0;
                  state_reg <= i2r_pkg::S_IDLE;
               end
            default:
               state_reg <= i2r_pkg::S_IDLE;
         endcase
      end
   end

   // *****************************************************
   // Address monitor
   // *****************************************************
   logic mon_active_reg;
   logic [3:0] mon_cnt_reg;
   logic [1:0] byte_idx_reg;
   logic [6:0] shift_reg;
   logic match_reg;
   logic match_seen_reg;
   logic start_det;
   logic stop_det;
   logic scl_rise;
   logic byte_done;
   logic [7:0] byte_w;
   logic addr_hit;
   assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
   assign stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
   assign scl_rise = scl_s & ~scl_q_reg;
   assign byte_done = scl_rise & mon_active_reg & (mon_cnt_reg == 4'h7);
   assign byte_w = {shift_reg, sda_s};
   assign addr_hit = ctrl_reg[i2r_pkg::CTRL_TEN] ?
                     (byte_idx_reg == 2'h1 && byte_w[6:0] == own_addr_reg) :
                     (byte_idx_reg == 2'h0 && byte_w[7:1] == own_addr_reg);
   assign addr_match_o = match_reg;
   assign status_w[i2r_pkg::ST_BUSY] = busy;
   assign status_w[i2r_pkg::ST_NACK] = nack_reg;
   assign status_w[i2r_pkg::ST_MATCH] = match_seen_reg;
   assign status_w[i2r_pkg::ST_SCL] = scl_s;
   assign status_w[i2r_pkg::ST_SDA] = sda_s;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         mon_active_reg <= 1'b0;
         mon_cnt_reg <= 4'h0;
         byte_idx_reg <= 2'h0;
         shift_reg <= 7'h00;
         match_reg <= 1'b0;
         match_seen_reg <= 1'b0;
      end
      else
      begin
         match_reg <= byte_done & addr_hit & ctrl_reg[i2r_pkg::CTRL_EN];
         if (start_det | stop_det)
         begin
            mon_active_reg <= start_det;
            mon_cnt_reg <= 4'h0;
            byte_idx_reg <= 2'h0;
            match_seen_reg <= 1'b0;
         end
         else if (scl_rise & mon_active_reg)
         begin
            if (mon_cnt_reg == 4'h8)
            begin
               mon_cnt_reg <= 4'h0;
               if (byte_idx_reg != 2'h3)
                  byte_idx_reg <= byte_idx_reg + 2'h1;
            end
            else
            begin
               shift_reg <= byte_w[6:0];
               mon_cnt_reg <= mon_cnt_reg + 4'h1;
            end
         end
         if (match_reg)
            match_seen_reg <= 1'b1;
      end
   end

   // *****************************************************
   // Checks
   // *****************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   chk_index_zero: assert property (
      rate_reg == 8'h00 |-> period == 16'd20 && sda_hold == 16'd7 &&
      start_hold == 16'd6 && stop_hold == 16'd11)
      else $error("index 00 values wrong");
   chk_index_last: assert property (
      rate_reg == 8'h1F |-> period == 16'd240 && sda_hold == 16'd33 &&
      start_hold == 16'd118 && stop_hold == 16'd121 ##0
      (rate_reg != 8'h3F || stop_hold == 16'd1921))
      else $error("index 1F values wrong");
   chk_scale_four: assert property (
      rate_reg == 8'hBF |-> period == 16'd15360 && sda_hold == 16'd2052)
      else $error("scale factor four wrong");
   chk_fastest_rate: assert property (
      period >= 16'd20)
      else $error("period below twenty");
   chk_sda_hold: assert property (
      state_reg == i2r_pkg::S_LOW && $changed(sda_oe_o) |-> cnt_reg == sda_hold)
      else $error("data changed at wrong time");
   chk_start_hold: assert property (
      $rose(scl_oe_o) && $past(state_reg) == i2r_pkg::S_START |->
      sda_oe_o && $past(cnt_reg) == start_hold - 16'h0001)
      else $error("start hold wrong");
   chk_stop_hold: assert property (
      $fell(sda_oe_o) && $past(state_reg) == i2r_pkg::S_STOP_HOLD |->
      !scl_oe_o && $past(cnt_reg) >= stop_hold - 16'h0001)
      else $error("stop hold wrong");
   chk_high_half: assert property (
      $rose(scl_oe_o) && $past(state_reg) == i2r_pkg::S_HIGH |->
      $past(cnt_reg) >= half_high - 16'h0001)
      else $error("high phase too short");
   chk_open_drain: assert property (
      scl_o == 1'b0 && sda_o == 1'b0 && (state_reg == i2r_pkg::S_IDLE ||
      state_reg == i2r_pkg::S_LOW || !$changed(sda_oe_o) ||
      state_reg == i2r_pkg::S_START || state_reg == i2r_pkg::S_STOP_LOW ||
      state_reg == i2r_pkg::S_STOP_HOLD))
      else $error("pin driven high");
   chk_match_seven: assert property (
      addr_match_o && !ctrl_reg[i2r_pkg::CTRL_TEN] |->
      $past(byte_w[7:1]) == $past(own_addr_reg) && match_seen_reg == 1'b0 ##1
      match_seen_reg)
      else $error("seven-bit match wrong");
   chk_match_ten: assert property (
      addr_match_o && ctrl_reg[i2r_pkg::CTRL_TEN] |->
      $past(byte_w[6:0]) == $past(own_addr_reg) && $past(byte_idx_reg) == 2'h1)
      else $error("ten-bit match wrong");
endmodule : i2r_rate_addr
`default_nettype wire

// ==== hw/i2r_pkg.sv ====
`default_nettype none
package i2r_pkg;
   // *****************************************************
   // Register offsets and fields
   // *****************************************************
   localparam logic [7:0] OFS_TARGET_ID = 8'h00;
   localparam logic [7:0] OFS_RATE = 8'h04;
   localparam logic [7:0] OFS_CTRL = 8'h08;
   localparam logic [7:0] OFS_CMD = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam int ID_ADDR_LSB = 1;
   localparam int RATE_IDX_LSB = 0;
   localparam int RATE_SCALE_LSB = 6;
   localparam int CTRL_EN = 0;
   localparam int CTRL_TEN = 1;
   localparam int CMD_START = 0;
   localparam int CMD_BYTE = 1;
   localparam int CMD_STOP = 2;
   localparam int CMD_DATA_LSB = 8;
   localparam int ST_BUSY = 0;
   localparam int ST_NACK = 1;
   localparam int ST_MATCH = 2;
   localparam int ST_SCL = 3;
   localparam int ST_SDA = 4;
   localparam logic [6:0] TARGET_ID_RST = 7'h00;
   localparam logic [7:0] RATE_RST = 8'h00;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [1:0] SCALE_X2 = 2'h1;
   localparam logic [1:0] SCALE_X4 = 2'h2;
   // *****************************************************
   // Divider and hold table, base indices 00 to 1F
   // *****************************************************
   typedef logic [31:0] i2r_entry_t;
   localparam i2r_entry_t RATE_TABLE [32] = '{
      32'h1407060B, 32'h1607070C, 32'h1808080D, 32'h1A08090E,
      32'h1C090A0F, 32'h1E090B10, 32'h220A0D12, 32'h280A1015,
      32'h1C070A0F, 32'h20070C11, 32'h24090E13, 32'h28091015,
      32'h2C0B1217, 32'h300B1419, 32'h380D181D, 32'h440D1E23,
      32'h30091219, 32'h3809161D, 32'h400D1A21, 32'h480D1E25,
      32'h50112229, 32'h5811262D, 32'h68152E35, 32'h80153A41,
      32'h50092629, 32'h60092E31, 32'h70113639, 32'h80113E41,
      32'h90194649, 32'hA0194E51, 32'hC0215E61, 32'hF0217679
   };
   typedef enum logic [2:0] {
      S_IDLE,
      S_START,
      S_LOW,
      S_HIGH,
      S_STOP_LOW,
      S_STOP_HOLD
   } i2r_state_t;
endpackage : i2r_pkg
`default_nettype wire

// ==== bench/i2r_target_model.sv ====
`default_nettype none
// ****************************************
// Bus target stand-in
// ****************************************
module i2r_target_model (
   // Clock
   input wire logic clk_i,
   // Bus lines
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_oe_o,
   output logic sda_oe_o,
   // Behaviour
   input wire logic ack_en_i,
   input wire logic [9:0] stretch_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic scl_reg = 1'b1;
   logic sda_reg = 1'b1;
   logic ack_reg = 1'b0;
   logic [3:0] bit_reg = 4'h0;
   logic [9:0] hold_reg = 10'h000;
   assign scl_oe_o = (hold_reg != 10'h000);
   assign sda_oe_o = ack_reg;
   always @(posedge clk_i)
   begin
      scl_reg <= scl_i;
      sda_reg <= sda_i;
      if (hold_reg != 10'h000)
         hold_reg <= hold_reg - 10'h001;
      if (scl_i && sda_reg && !sda_i)
         bit_reg <= 4'h0;
      else if (!scl_reg && scl_i)
         bit_reg <= bit_reg + 4'h1;
      else if (scl_reg && !scl_i && bit_reg == 4'h8)
      begin
         ack_reg <= ack_en_i;
         hold_reg <= stretch_i;
      end
      else if (scl_reg && !scl_i && bit_reg == 4'h9)
      begin
         ack_reg <= 1'b0;
         bit_reg <= 4'h0;
      end
   end
endmodule : i2r_target_model
`default_nettype wire

// ==== bench/i2r_rate_addr_tb.sv ====
`default_nettype none
module i2r_rate_addr_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [34:0] SKIP = {1'b1, 34'h0};
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, addr_match;
   logic m_scl_oe, m_sda_oe;
   logic m_ack = 1'b1;
   logic [9:0] m_stretch = 10'h000;
   logic scl_w, sda_w;
   logic [34:0] note;
   logic ps = 1'b1;
   logic pd = 1'b1;
   int n_errors = 0;
   int samples_checked = 0;
   int match_cnt = 0;
   int t = 0;
   int t_st, t_f, t_f2, t_r;
   int nf = 9;
   logic [34:0] exp_q[$];
   int tim_q[$];
   // ****************************************
   // Transfer cases
   // ****************************************
   logic [7:0] rt [5] = '{8'h00, 8'h5F, 8'h8B, 8'hD4, 8'h20};
   int dv [5] = '{20, 240, 40, 80, 160};
   int sh [5] = '{7, 33, 9, 17, 17};
   int st [5] = '{6, 118, 16, 34, 78};
   int sp [5] = '{11, 121, 21, 41, 81};
   assign scl_w = (scl_oe ? scl_o : 1'b1) & ~m_scl_oe;
   assign sda_w = (sda_oe ? sda_o : 1'b1) & ~m_sda_oe;
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   i2r_rate_addr dut_u (
      .clk_i(clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .addr_match_o(addr_match)
   );
   i2r_target_model model_u (
      .clk_i(clk), .scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl_oe),
      .sda_oe_o(m_sda_oe), .ack_en_i(m_ack), .stretch_i(m_stretch)
   );
   // ****************************************
   // Helpers
   // ****************************************
   task automatic finish_test();
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [32:0] act, input logic [32:0] exp);
      samples_checked++;
      if (act !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, act, exp);
      end
   endtask : chk
   task automatic tchk(input int v);
      int e;
      e = (tim_q.size() != 0) ? tim_q.pop_front() : -1;
      chk(33'(v), 33'(e));
   endtask : tchk
   function automatic logic [34:0] rn(input logic e, input logic [31:0] d);
      return {2'b01, e, d};
   endfunction : rn
   function automatic logic [34:0] wn(input logic e);
      return {2'b00, e, 32'h0};
   endfunction : wn
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction : lfsr
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [34:0] nt, output logic [31:0] rd);
      int n;
      exp_q.push_back(nt);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         n_errors++;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic idle_wait();
      logic [31:0] r;
      int n;
      n = 0;
      do
      begin
         apb(1'b0, i2r_pkg::OFS_STATUS, 32'h0, SKIP, r);
         n++;
      end
      while (r[i2r_pkg::ST_BUSY] !== 1'b0 && n < 8000);
      if (n >= 8000)
         n_errors++;
   endtask : idle_wait
   task automatic push_tim(input int c);
      int f;
      f = (rt[c][7:6] == 2'h1) ? 2 : ((rt[c][7:6] == 2'h2) ? 4 : 1);
      tim_q.push_back(st[c] * f);
      tim_q.push_back(sh[c] * f);
      tim_q.push_back(dv[c] * f);
      tim_q.push_back(sp[c] * f);
   endtask : push_tim
   task automatic xfer(input int c, input logic [7:0] b, input logic ack);
      logic [31:0] r;
      push_tim(c);
      m_ack <= ack;
      apb(1'b1, i2r_pkg::OFS_RATE, {24'h0, rt[c]}, wn(1'b0), r);
      apb(1'b1, i2r_pkg::OFS_CMD, {16'h0, b, 8'h07}, wn(1'b0), r);
      idle_wait();
      apb(1'b0, i2r_pkg::OFS_STATUS, 32'h0, rn(1'b0, {27'h0, 3'h6, !ack, 1'b0}), r);
   endtask : xfer
   // ****************************************
   // Result watchers
   // ****************************************
   always @(posedge clk)
   begin
      if (psel && penable && pready === 1'b1 && exp_q.size() != 0)
      begin
         note = exp_q.pop_front();
         if (!note[34] && note[33])
            chk({pslverr, prdata}, note[32:0]);
         else if (!note[34])
            chk({pslverr, 32'h0}, {note[32], 32'h0});
      end
   end
   always @(negedge clk)
   begin
      t = t + 1;
      if (addr_match === 1'b1)
         match_cnt++;
      if (pd && !sda_w && scl_w)
      begin
         t_st = t;
         nf = -1;
      end
      if (ps && !scl_w)
      begin
         nf++;
         if (nf == 0)
            tchk(t - t_st);
         if (nf == 2)
            t_f2 = t;
         if (nf == 3)
            tchk(t - t_f2);
         t_f = t;
      end
      if (!pd && sda_w && !scl_w && nf == 0)
         tchk(t - t_f);
      if (!ps && scl_w)
         t_r = t;
      if (!pd && sda_w && scl_w)
         tchk(t - t_r);
      ps = scl_w;
      pd = sda_w;
   end
   initial
   begin
      repeat (80000) @(posedge clk);
      n_errors++;
      finish_test();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      logic [31:0] r;
      logic [31:0] v;
      int i;
      int m;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      apb(1'b0, i2r_pkg::OFS_TARGET_ID, 32'h0, rn(1'b0, 32'h0), r);
      apb(1'b0, i2r_pkg::OFS_RATE, 32'h0, rn(1'b0, 32'h0), r);
      apb(1'b0, i2r_pkg::OFS_CMD, 32'h0, rn(1'b0, 32'h0), r);
      apb(1'b0, i2r_pkg::OFS_STATUS, 32'h0, rn(1'b0, 32'h18), r);
      v = 32'h75f5;
      for (i = 0; i < 4; i++)
      begin
         v = lfsr(v);
         apb(1'b1, i2r_pkg::OFS_TARGET_ID, v, wn(1'b0), r);
         apb(1'b0, i2r_pkg::OFS_TARGET_ID, 32'h0, rn(1'b0, {24'h0, v[7:1], 1'b0}), r);
         apb(1'b1, i2r_pkg::OFS_RATE, v, wn(1'b0), r);
         apb(1'b0, i2r_pkg::OFS_RATE, 32'h0, rn(1'b0, {24'h0, v[7:0]}), r);
      end
      apb(1'b1, 8'h14, v, wn(1'b1), r);
      apb(1'b0, 8'h14, 32'h0, rn(1'b1, 32'h0), r);
      apb(1'b1, i2r_pkg::OFS_TARGET_ID, 32'hB6, wn(1'b0), r);
      apb(1'b1, i2r_pkg::OFS_CTRL, 32'h1, wn(1'b0), r);
      m_stretch <= 10'h0C8;
      for (i = 0; i < 5; i++)
      begin
         m = match_cnt;
         xfer(i, (i == 2) ? 8'hA5 : 8'hB6, 1'b1);
         chk(33'(match_cnt - m), (i == 2) ? 33'h0 : 33'h1);
      end
      m_stretch <= 10'h000;
      xfer(0, 8'hB6, 1'b0);
      m_ack <= 1'b1;
      apb(1'b1, i2r_pkg::OFS_TARGET_ID, 32'hF0, wn(1'b0), r);
      apb(1'b1, i2r_pkg::OFS_CTRL, 32'h3, wn(1'b0), r);
      m = match_cnt;
      push_tim(0);
      apb(1'b1, i2r_pkg::OFS_CMD, 32'hF003, wn(1'b0), r);
      idle_wait();
      apb(1'b1, i2r_pkg::OFS_CMD, 32'h7806, wn(1'b0), r);
      idle_wait();
      chk(33'(match_cnt - m), 33'h1);
      chk(33'(tim_q.size()), 33'h0);
      finish_test();
   end
endmodule : i2r_rate_addr_tb
`default_nettype wire
